// ==== design/read_checker_consts.vh ====
`ifndef READ_CHECKER_CONSTS_VH
`define READ_CHECKER_CONSTS_VH
// ----------------------------------------
// register byte addresses
// ----------------------------------------
`define REG_CTRL 8'h00
`define REG_RATE 8'h04
`define REG_CMD 8'h08
`define REG_CMD_COUNT 8'h0c
`define REG_STATUS 8'h10
`define REG_EXP_BASE 8'h20
`define REG_RCV_BASE 8'h40
`define REG_AREA_MASK 8'he0
// ----------------------------------------
// reset values and field codes
// ----------------------------------------
`define CTRL_RST 4'h8
`define CTRL_VERIFY_BIT 3
`define RATE_RST 7'h64
`define OPCODE_RST 3'h0
`define CMD_COUNT_RST 9'h000
`define OP_READ 3'h3
`define PAT_INC 3'h0
`define PAT_DEC 3'h1
`define PAT_ZERO 3'h2
`define PAT_ONE 3'h3
`define PAT_LFSR 3'h4
// ----------------------------------------
// counts and positions
// ----------------------------------------
`define RATE_WINDOW 7'h64
`define RATE_WINDOW_LAST 7'h63
`define LAST_WORD 7'h7f
`define FIRST_WORD 7'h00
`define ALIGN_TAP 3
`define STAT_FAIL_BIT 0
`define STAT_AWAIT_BIT 16
`define LFSR_TAP_A 21
`define LFSR_TAP_B 1
`endif

// ==== design/throughput_gate_gen.v ====
`timescale 1ns/100ps
`default_nettype none
`include "read_checker_consts.vh"
module throughput_gate_gen (
  // clock and reset
  input wire clk,
  input wire rstn,
  // programmed rate in percent
  input wire [6:0] throughput_percent,
  // high while the stream may flow
  output wire throughput_gate
);
  reg [6:0] slot_ff; // position inside the 100-cycle window
  reg gate_ff; // registered gate
  wire [6:0] nxt_slot;
  // ----------------------------------------
  // window counter and duty compare
  // ----------------------------------------
  assign nxt_slot = (slot_ff == `RATE_WINDOW_LAST) ? 7'h00 : slot_ff + 7'h01;
  // gate stays high for the first rate slots, low for the rest
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      slot_ff <= 7'h00;
      gate_ff <= 1'b0;
    end else begin
      slot_ff <= nxt_slot;
      gate_ff <= (nxt_slot < throughput_percent);
    end
  end
  assign throughput_gate = gate_ff;
endmodule
`default_nettype wire

// ==== design/lfsr_lookahead.v ====
`timescale 1ns/100ps
`default_nettype none
`include "read_checker_consts.vh"
module lfsr_lookahead (
  // state for the first dword of this word
  input wire [31:0] seed,
  // eight successive dwords, dword 0 in the low bits
  output wire [255:0] dwords,
  // state for the first dword of the next word
  output wire [31:0] next_seed
);
  // ----------------------------------------
  // one dword worth of fibonacci shifts
  // ----------------------------------------
  // taps 31, 21, 1 and 0 give x^31 + x^21 + x + 1
  function [31:0] advance;
    input [31:0] s;
    integer i;
    reg [31:0] t;
    begin
      t = s;
      for (i = 0; i < 32; i = i + 1) begin
        t = {t[30:0], t[31] ^ t[`LFSR_TAP_A] ^ t[`LFSR_TAP_B] ^ t[0]};
      end
      advance = t;
    end
  endfunction
  wire [31:0] chain [0:8]; // states along the word
  assign chain[0] = seed;
  genvar j;
  // unrolled chain so all eight dwords come in one cycle
  generate
    for (j = 0; j < 8; j = j + 1) begin : g_step
      assign dwords[32*j +: 32] = chain[j];
      assign chain[j+1] = advance(chain[j]);
    end
  endgenerate
  assign next_seed = chain[8];
endmodule
`default_nettype wire

// ==== design/read_checker.v ====
// How it works
// - hold is the inverted throughput gate
// - word counter runs 0..127 on valid
// - first word clears await, pops header once
// - first expected word carries popped 48-bit address
// - first expected word ready four cycles later
// - read word delayed, mismatch raises fail
// - fail shows expected, received and position
// - compare only when four-cycle-delayed valid high
// - valid at word 127 rearms await flag
// - read data path is 256 bits
// - cpu sources single, generator sources read requests
// - generator requests reads only; opcode from register
// - gate high rate cycles per 100
// - block head: 48-bit address zero-padded, then pattern
// - all-zero and all-one blocks have no header
// - lfsr is fibonacci x^31+x^21+x+1
`timescale 1ns/100ps
`default_nettype none
`include "read_checker_consts.vh"
module read_checker (
  // clock and reset
  input wire clk,
  input wire rstn,
  // read stream from the controller core
  input wire read_word_valid,
  input wire [255:0] read_word,
  output wire read_stream_hold,
  // header fifo, first word falls through
  input wire [47:0] header_fifo_out,
  output wire header_fifo_pop,
  // command side of the main user port
  input wire main_port_ready,
  output wire [2:0] main_port_opcode,
  output wire main_port_request,
  // compare results
  output wire compare_fail_flag,
  output wire [255:0] fail_expected_value,
  output wire [255:0] fail_received_value,
  output wire [6:0] fail_position,
  // register port
  input wire [7:0] reg_addr,
  input wire [31:0] reg_wr_data,
  input wire reg_wr,
  input wire reg_rd,
  output wire [31:0] reg_rd_data
);
  // ----------------------------------------
  // software registers
  // ----------------------------------------
  reg [3:0] ctrl_ff; // pattern select and verify enable
  reg [6:0] rate_ff; // throughput in percent
  reg [2:0] opcode_ff; // command code for the main port
  reg [8:0] cmd_count_ff; // read requests per start
  reg [31:0] reg_rd_data_ff; // read answer
  reg [31:0] nxt_rd_data;
  wire wr_ctrl;
  wire wr_rate;
  wire wr_cmd;
  wire wr_count;
  wire [2:0] pattern_sel;
  wire verify_on;
  assign wr_ctrl = reg_wr && (reg_addr == `REG_CTRL);
  assign wr_rate = reg_wr && (reg_addr == `REG_RATE);
  assign wr_cmd = reg_wr && (reg_addr == `REG_CMD);
  assign wr_count = reg_wr && (reg_addr == `REG_CMD_COUNT);
  assign pattern_sel = ctrl_ff[2:0];
  assign verify_on = ctrl_ff[`CTRL_VERIFY_BIT];
  // plain stores, no side effects except the command write
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ctrl_ff <= `CTRL_RST;
      rate_ff <= `RATE_RST;
      opcode_ff <= `OPCODE_RST;
      cmd_count_ff <= `CMD_COUNT_RST;
    end else begin
      if (wr_ctrl) begin
        ctrl_ff <= reg_wr_data[3:0];
      end
      if (wr_rate) begin
        rate_ff <= reg_wr_data[6:0];
      end
      if (wr_cmd) begin
        opcode_ff <= reg_wr_data[2:0];
      end
      if (wr_count) begin
        cmd_count_ff <= reg_wr_data[8:0];
      end
    end
  end
  // ----------------------------------------
  // command requests
  // ----------------------------------------
  reg [8:0] remaining_ff; // read requests still to send
  reg main_port_request_ff;
  wire cpu_single_request;
  wire generator_read_request;
  // a non-read opcode write is one single-mode request
  assign cpu_single_request = wr_cmd && (reg_wr_data[2:0] != `OP_READ);
  // the generator only ever asks for reads, paced by ready; a later single-mode
  // write changes the opcode, so leftover read requests are dropped when the next read start reloads the count
  assign generator_read_request = (remaining_ff != 9'h000) && main_port_ready &&
                                  (opcode_ff == `OP_READ);
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      remaining_ff <= 9'h000;
      main_port_request_ff <= 1'b0;
    end else begin
      if (wr_cmd && (reg_wr_data[2:0] == `OP_READ)) begin
        remaining_ff <= cmd_count_ff;
      end else if (generator_read_request) begin
        remaining_ff <= remaining_ff - 9'h001;
      end
      // a single-mode write in the same cycle as a generator request merges both into one request pulse
      main_port_request_ff <= cpu_single_request | generator_read_request;
    end
  end
  // ----------------------------------------
  // rate limiter
  // ----------------------------------------
  wire throughput_gate;
  reg read_stream_hold_ff;
  throughput_gate_gen u_gate (
    .clk(clk),
    .rstn(rstn),
    .throughput_percent(rate_ff),
    .throughput_gate(throughput_gate)
  );
  // the core reacts within four cycles, so this extra flop is harmless
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      read_stream_hold_ff <= 1'b1;
    end else begin
      read_stream_hold_ff <= ~throughput_gate;
    end
  end
  // ----------------------------------------
  // block tracking
  // ----------------------------------------
  reg [6:0] block_word_count_ff; // word index inside the 4 KB block
  reg await_block_head_ff; // waiting for a block's first word
  reg header_fifo_pop_ff;
  wire [6:0] block_word_count_tap;
  wire head_seen;
  assign block_word_count_tap = block_word_count_ff;
  assign head_seen = read_word_valid && await_block_head_ff;
  // 7-bit counter wraps from 127 to 0 by itself
  // the rearm at word 127 is tested first so a new block is always caught
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      block_word_count_ff <= `FIRST_WORD;
      await_block_head_ff <= 1'b1;
      header_fifo_pop_ff <= 1'b0;
    end else begin
      if (read_word_valid) begin
        block_word_count_ff <= block_word_count_ff + 7'h01;
      end
      if (read_word_valid && (block_word_count_tap == `LAST_WORD)) begin
        await_block_head_ff <= 1'b1;
      end else if (head_seen) begin
        await_block_head_ff <= 1'b0;
      end
      header_fifo_pop_ff <= head_seen;
    end
  end
  // ----------------------------------------
  // alignment pipeline, four stages
  // ----------------------------------------
  reg [3:0] valid_delay_line_ff; // bit n is valid delayed n+1 cycles
  reg [6:0] cnt1_ff;
  reg [6:0] cnt2_ff;
  reg [6:0] cnt3_ff;
  reg [6:0] cnt4_ff;
  reg [255:0] rd1_ff;
  reg [255:0] rd2_ff;
  reg [255:0] rd3_ff;
  reg [255:0] read_word_aligned_ff;
  // read data is held back to meet the expected word
  // the count rides along so a failure reports the word index, not a cycle
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      valid_delay_line_ff <= 4'h0;
      cnt1_ff <= `FIRST_WORD;
      cnt2_ff <= `FIRST_WORD;
      cnt3_ff <= `FIRST_WORD;
      cnt4_ff <= `FIRST_WORD;
      rd1_ff <= 256'h0;
      rd2_ff <= 256'h0;
      rd3_ff <= 256'h0;
      read_word_aligned_ff <= 256'h0;
    end else begin
      valid_delay_line_ff <= {valid_delay_line_ff[2:0], read_word_valid};
      cnt1_ff <= block_word_count_tap;
      cnt2_ff <= cnt1_ff;
      cnt3_ff <= cnt2_ff;
      cnt4_ff <= cnt3_ff;
      rd1_ff <= read_word;
      rd2_ff <= rd1_ff;
      rd3_ff <= rd2_ff;
      read_word_aligned_ff <= rd3_ff;
    end
  end
  // ----------------------------------------
  // expected pattern generator
  // ----------------------------------------
  reg [47:0] head_addr_ff; // address of the current block
  reg [31:0] lfsr_ff; // lfsr state for the word in stage two
  reg [255:0] expected_word_ff;
  reg [255:0] expected_word_aligned_ff;
  wire [255:0] lfsr_dwords;
  wire [31:0] lfsr_next;
  wire [255:0] first_expected_word;
  wire has_header;
  lfsr_lookahead u_lfsr (
    .seed(lfsr_ff),
    .dwords(lfsr_dwords),
    .next_seed(lfsr_next)
  );
  // constant patterns carry no header at all
  assign has_header = (cnt2_ff == `FIRST_WORD) && (pattern_sel != `PAT_ZERO) &&
                      (pattern_sel != `PAT_ONE);
  genvar j;
  // one dword lane per loop pass
  generate
    for (j = 0; j < 8; j = j + 1) begin : g_lane
      localparam [2:0] LANE = j;
      wire [31:0] inc_dw;
      wire [31:0] body_dw;
      wire [31:0] head_dw;
      assign inc_dw = {head_addr_ff[21:0], cnt2_ff, LANE};
      assign body_dw = (pattern_sel == `PAT_INC) ? inc_dw :
                       (pattern_sel == `PAT_DEC) ? ~inc_dw :
                       (pattern_sel == `PAT_ONE) ? 32'hffffffff :
                       (pattern_sel == `PAT_LFSR) ? lfsr_dwords[32*j +: 32] : 32'h00000000;
      // the first two dwords hold the zero-padded address
      assign head_dw = (j == 0) ? head_addr_ff[31:0] : {16'h0000, head_addr_ff[47:32]};
      assign first_expected_word[32*j +: 32] = (has_header && (j < 2)) ? head_dw : body_dw;
    end
  endgenerate
  // header is sampled while the pop pulse stands
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      head_addr_ff <= 48'h0;
      lfsr_ff <= 32'h0;
      expected_word_ff <= 256'h0;
      expected_word_aligned_ff <= 256'h0;
    end else begin
      if (header_fifo_pop_ff) begin
        head_addr_ff <= header_fifo_out;
        // reseeding wins over stepping the previous block's last word
        lfsr_ff <= {header_fifo_out[15:0], ~header_fifo_out[15:0]};
      end else if (valid_delay_line_ff[1]) begin
        lfsr_ff <= lfsr_next;
      end
      expected_word_ff <= first_expected_word;
      expected_word_aligned_ff <= expected_word_ff;
    end
  end
  // ----------------------------------------
  // verification and first-failure capture
  // ----------------------------------------
  reg compare_fail_flag_ff;
  reg [255:0] fail_expected_value_ff;
  reg [255:0] fail_received_value_ff;
  reg [6:0] fail_position_ff;
  wire mismatch;
  // nothing is checked while the delayed valid is low
  assign mismatch = verify_on && valid_delay_line_ff[`ALIGN_TAP] &&
                    (read_word_aligned_ff != expected_word_aligned_ff);
  // only the first failure is kept so software sees the root cause
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      compare_fail_flag_ff <= 1'b0;
      fail_expected_value_ff <= 256'h0;
      fail_received_value_ff <= 256'h0;
      fail_position_ff <= `FIRST_WORD;
    end else if (mismatch && !compare_fail_flag_ff) begin
      compare_fail_flag_ff <= 1'b1;
      fail_expected_value_ff <= expected_word_aligned_ff;
      fail_received_value_ff <= read_word_aligned_ff;
      fail_position_ff <= cnt4_ff;
    end
  end
  // ----------------------------------------
  // register read mux
  // ----------------------------------------
  // answer stands one cycle after the strobe; unmapped reads give zero
  // the captured words are read as eight dwords, lowest dword at the base
  always @* begin
    nxt_rd_data = 32'h0;
    if (reg_rd) begin
      if ((reg_addr & `REG_AREA_MASK) == `REG_EXP_BASE) begin
        nxt_rd_data = fail_expected_value_ff[{reg_addr[4:2], 5'h00} +: 32];
      end else if ((reg_addr & `REG_AREA_MASK) == `REG_RCV_BASE) begin
        nxt_rd_data = fail_received_value_ff[{reg_addr[4:2], 5'h00} +: 32];
      end else begin
        case (reg_addr)
          `REG_CTRL: begin
            nxt_rd_data = {28'h0, ctrl_ff};
          end
          `REG_RATE: begin
            nxt_rd_data = {25'h0, rate_ff};
          end
          `REG_CMD: begin
            nxt_rd_data = {29'h0, opcode_ff};
          end
          `REG_CMD_COUNT: begin
            nxt_rd_data = {23'h0, cmd_count_ff};
          end
          `REG_STATUS: begin
            nxt_rd_data = {15'h0, await_block_head_ff, 1'b0, fail_position_ff, 7'h0, compare_fail_flag_ff};
          end
          default: begin
            nxt_rd_data = 32'h0;
          end
        endcase
      end
    end
  end
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      reg_rd_data_ff <= 32'h0;
    end else begin
      reg_rd_data_ff <= nxt_rd_data;
    end
  end
  // ----------------------------------------
  // outputs, all from flops
  // ----------------------------------------
  // the core stops valid within four cycles of hold
  assign read_stream_hold = read_stream_hold_ff;
  assign header_fifo_pop = header_fifo_pop_ff;
  assign main_port_opcode = opcode_ff;
  assign main_port_request = main_port_request_ff;
  assign compare_fail_flag = compare_fail_flag_ff;
  assign fail_expected_value = fail_expected_value_ff;
  assign fail_received_value = fail_received_value_ff;
  assign fail_position = fail_position_ff;
  assign reg_rd_data = reg_rd_data_ff;
endmodule
`default_nettype wire

// ==== verification/read_checker_monitor.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "read_checker_consts.vh"
module read_checker_monitor (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // stream and header side
  input wire logic read_word_valid,
  input wire logic header_fifo_pop,
  // command side
  input wire logic main_port_ready,
  input wire logic main_port_request,
  input wire logic [2:0] main_port_opcode,
  // compare results
  input wire logic compare_fail_flag,
  input wire logic [255:0] fail_expected_value,
  input wire logic [255:0] fail_received_value,
  input wire logic [6:0] fail_position,
  // register writes
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wr_data,
  input wire logic reg_wr
);
  // ----------------------------------------
  // one domain, so clock and reset are shared
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  // a block holds 128 words, so a second pop can never follow closely
  AST_POP_PULSE: assert property (header_fifo_pop |=> !header_fifo_pop [*8])
    else $error("header pop is not a lone pulse");
  AST_POP_CAUSE: assert property (header_fifo_pop |-> $past(read_word_valid))
    else $error("header pop without a first word");
  AST_FAIL_STICKY: assert property (compare_fail_flag |=> compare_fail_flag)
    else $error("fail flag dropped before reset");
  AST_FAIL_HOLD: assert property (compare_fail_flag |=> $stable(fail_expected_value) &&
    $stable(fail_received_value) && $stable(fail_position)) else $error("fail details moved");
  AST_FAIL_DIFF: assert property ($rose(compare_fail_flag) |->
    fail_expected_value != fail_received_value) else $error("fail raised on equal words");
  // the compared word entered five edges before the flag shows
  AST_FAIL_VALID: assert property ($rose(compare_fail_flag) |-> $past(read_word_valid, 5))
    else $error("fail raised on a slot without valid");
  AST_REQ_CAUSE: assert property (main_port_request |->
    $past(reg_wr && reg_addr == `REG_CMD) || $past(main_port_ready)) else $error("request without cause");
  AST_OPCODE: assert property (reg_wr && reg_addr == `REG_CMD |=>
    main_port_opcode == $past(reg_wr_data[2:0])) else $error("opcode not taken from register");
endmodule
bind read_checker read_checker_monitor u_mon (
  .clk(clk), .rstn(rstn), .read_word_valid(read_word_valid), .header_fifo_pop(header_fifo_pop),
  .main_port_ready(main_port_ready), .main_port_request(main_port_request),
  .main_port_opcode(main_port_opcode), .compare_fail_flag(compare_fail_flag),
  .fail_expected_value(fail_expected_value), .fail_received_value(fail_received_value),
  .fail_position(fail_position), .reg_addr(reg_addr), .reg_wr_data(reg_wr_data), .reg_wr(reg_wr));
`default_nettype wire

// ==== verification/read_port_model.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "read_checker_consts.vh"
module read_port_model (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // command side
  input wire logic main_port_request,
  input wire logic [2:0] main_port_opcode,
  output logic main_port_ready,
  // read stream and header fifo
  input wire logic read_stream_hold,
  output logic read_word_valid,
  output logic [255:0] read_word,
  input wire logic header_fifo_pop,
  output logic [47:0] header_fifo_out,
  // bench controls
  input wire logic [47:0] next_addr,
  input wire logic [2:0] pattern,
  input wire logic [7:0] bad_from,
  input wire logic stall,
  output logic busy
);
  logic [47:0] hq[$]; // header fifo contents
  logic [47:0] dq[$]; // blocks still to stream
  logic [2:0] hold_q; // hold seen over the last edges
  int idx; // word index in the current block
  // word builder; words from bad_from on get bit 0 flipped
  function automatic logic [255:0] mk_word(input logic [2:0] p, input logic [47:0] a, input int i,
    input logic bad);
    logic [31:0] d, s;
    s = {a[15:0], ~a[15:0]}; // lfsr state of word 0
    if (p == `PAT_LFSR) repeat (256 * i) s = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    for (int j = 0; j < 8; j++) begin
      d = {a[21:0], i[6:0], j[2:0]};
      if (p == `PAT_DEC) d = ~d;
      if (p == `PAT_ZERO) d = 32'h0;
      if (p == `PAT_ONE) d = 32'hffffffff;
      if (p == `PAT_LFSR) d = s;
      if (i == 0 && j < 2 && p != `PAT_ZERO && p != `PAT_ONE)
        d = j ? {16'h0, a[47:32]} : a[31:0];
      mk_word[32*j +: 32] = d;
      repeat (32) s = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    end
    if (bad) mk_word[0] = ~mk_word[0];
  endfunction
  // ----------------------------------------
  // command queue and stream
  // ----------------------------------------
  // stopping four cycles after hold is the slowest the core is allowed
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      hq.delete();
      dq.delete();
      idx = 0;
      hold_q <= 3'h7;
      read_word_valid <= 1'b0;
      read_word <= '0;
      header_fifo_out <= '0;
      main_port_ready <= 1'b0;
      busy <= 1'b0;
    end else begin
      hold_q <= {hold_q[1:0], read_stream_hold};
      if (header_fifo_pop) void'(hq.pop_front());
      if (main_port_request && main_port_opcode == `OP_READ) begin
        hq.push_back(next_addr);
        dq.push_back(next_addr);
      end
      read_word_valid <= 1'b0;
      read_word <= ~read_word; // idle bus never repeats the last word
      if (dq.size() != 0 && !hold_q[2] && !stall) begin
        read_word_valid <= 1'b1;
        read_word <= mk_word(pattern, dq[0], idx, idx >= bad_from);
        idx++;
        if (idx == 128) begin
          idx = 0;
          void'(dq.pop_front());
        end
      end
      header_fifo_out <= hq.size() != 0 ? hq[0] : ~header_fifo_out;
      main_port_ready <= dq.size() < 256;
      busy <= dq.size() != 0;
    end
  end
endmodule
`default_nettype wire

// ==== verification/read_checker_tb.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "read_checker_consts.vh"
module read_checker_tb;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic clk, rstn, reg_wr, reg_rd, stall; // bench-driven controls
  logic [7:0] reg_addr, bad_from;
  logic [31:0] reg_wr_data, v, seed;
  logic [47:0] next_addr;
  logic [2:0] pattern;
  logic [255:0] e;
  wire hold, pop, req, rdy, valid, fail, busy;
  wire [2:0] opc;
  wire [47:0] hdr;
  wire [255:0] rword, fexp, frcv;
  wire [6:0] fpos;
  wire [31:0] rdata;
  int error_cnt, check_count, req_cnt, i;
  logic [2:0] ops [4] = '{3'h0, 3'h1, 3'h4, 3'h6}; // single-mode opcodes
  // ----------------------------------------
  // design and far side
  // ----------------------------------------
  read_checker DUT (.clk(clk), .rstn(rstn), .read_word_valid(valid), .read_word(rword),
    .read_stream_hold(hold), .header_fifo_out(hdr), .header_fifo_pop(pop), .main_port_ready(rdy),
    .main_port_opcode(opc), .main_port_request(req), .compare_fail_flag(fail),
    .fail_expected_value(fexp), .fail_received_value(frcv), .fail_position(fpos),
    .reg_addr(reg_addr), .reg_wr_data(reg_wr_data), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rd_data(rdata));
  read_port_model u_core (.clk(clk), .rstn(rstn), .main_port_request(req), .main_port_opcode(opc),
    .main_port_ready(rdy), .read_stream_hold(hold), .read_word_valid(valid), .read_word(rword),
    .header_fifo_pop(pop), .header_fifo_out(hdr), .next_addr(next_addr), .pattern(pattern),
    .bad_from(bad_from), .stall(stall), .busy(busy));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // random far-side stalls and a request tally
  always @(posedge clk) begin
    stall <= ($random(seed) & 3) == 0;
    if (req === 1'b1) req_cnt++;
  end
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic chk(input string n, input logic [255:0] s, input logic [255:0] x);
    check_count++;
    if (s !== x) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", n, x, s);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wr_data <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    d = rdata;
  endtask
  // over any 100 cycles the gate is open exactly rate cycles
  task automatic rate_chk(input logic [6:0] r);
    int c;
    wr(`REG_RATE, {25'h0, r});
    repeat (210) @(posedge clk);
    c = 0;
    repeat (100) begin
      @(negedge clk);
      c += !hold;
    end
    chk("open cycles", c, r);
  endtask
  // one read command run of the given number of blocks
  task automatic run(input logic [3:0] ctl, input logic [7:0] bad, input int blocks);
    int r, k;
    pattern <= ctl[2:0];
    bad_from <= bad;
    next_addr[31:0] <= $random(seed);
    next_addr[47:32] <= 16'($random(seed));
    wr(`REG_CTRL, {28'h0, ctl});
    wr(`REG_CMD_COUNT, 32'(blocks));
    r = req_cnt;
    wr(`REG_CMD, {29'h0, `OP_READ});
    repeat (5) @(posedge clk);
    k = 0;
    while (busy && k < 20000) begin
      @(posedge clk);
      k++;
    end
    repeat (12) @(posedge clk);
    chk("stream end", busy, 1'b0);
    chk("read requests", req_cnt - r, blocks);
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // ----------------------------------------
  // sequence
  // ----------------------------------------
  initial begin
    seed = 32'h6d4e;
    {rstn, reg_wr, reg_rd, reg_addr, reg_wr_data, pattern, next_addr} = '0;
    bad_from = 8'hff;
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    rd(`REG_CTRL, v);
    chk("ctrl reset", v, `CTRL_RST);
    rd(`REG_RATE, v);
    chk("rate reset", v, `RATE_RST);
    rd(`REG_CMD_COUNT, v);
    chk("count reset", v, `CMD_COUNT_RST);
    rd(8'hfc, v);
    chk("unmapped read", v, 0);
    $display("register test done");
    rate_chk(7'h28);
    rate_chk(7'h64);
    $display("rate test done");
    foreach (ops[k]) begin
      i = req_cnt;
      wr(`REG_CMD, {29'h0, ops[k]});
      repeat (3) @(posedge clk);
      chk("single request", req_cnt - i, 1);
      chk("opcode", opc, ops[k]);
    end
    $display("single command test done");
    wr(`REG_RATE, 32'h28);
    for (int p = 0; p <= `PAT_LFSR; p++) begin
      run({1'b1, 3'(p)}, 8'hff, 2);
      chk("clean blocks", fail, 0);
    end
    run(4'h0, 8'h05, 1);
    chk("verify off", fail, 0);
    $display("pattern test done");
    i = 1 + ($unsigned($random(seed)) % 127);
    run(4'h8, 8'(i), 1);
    e = u_core.mk_word(`PAT_INC, next_addr, i, 1'b0);
    chk("fail flag", fail, 1);
    chk("fail position", fpos, i);
    chk("fail expected", fexp, e);
    chk("fail received", frcv, u_core.mk_word(`PAT_INC, next_addr, i, 1'b1));
    rd(`REG_STATUS, v);
    chk("status", {v[14:8], v[0]}, {7'(i), 1'b1});
    rd(`REG_EXP_BASE + 8'h1c, v);
    chk("expected dword 7", v, e[255:224]);
    rd(`REG_RCV_BASE, v);
    chk("received dword 0", v, e[31:0] ^ 32'h1);
    run(4'h8, 8'h00, 1);
    chk("first fail kept", {fpos, fexp}, {7'(i), e});
    $display("mismatch test done");
    complete_run;
  end
  // hang guard well past the longest sequence
  initial begin
    repeat (60000) @(posedge clk);
    error_cnt++;
    complete_run;
  end
endmodule
`default_nettype wire
